// *** rtl/pcm_pkg.sv ***
package pcm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] PCM_IDX_POWER_CONTROL = 8'h87;
	localparam logic [7:0] PCM_IDX_DIVIDER = 8'h95;
	localparam logic [7:0] PCM_IDX_POWER_MONITOR = 8'ha3;
	localparam logic [7:0] PCM_IDX_TA_KEY = 8'hc7;
	localparam logic [7:0] PCM_IDX_CLOCK_CFG = 8'hf2;
	localparam logic [7:0] PCM_IDX_BROWNOUT_CFG = 8'hf3;
	localparam int PCM_ADDR_W = 10;
	// Timed-access key bytes and window length
	localparam logic [7:0] PCM_TA_KEY1 = 8'haa;
	localparam logic [7:0] PCM_TA_KEY2 = 8'h55;
	localparam logic [3:0] PCM_TA_WINDOW = 4'h8;
	// Power control fields
	localparam int PCM_IDLE_BIT = 0;
	localparam int PCM_PD_BIT = 1;
	localparam int PCM_POF_BIT = 4;
	// Power monitor fields
	localparam int PCM_BOF_BIT = 3;
	localparam int PCM_BROWNOUT_RESET_ENABLE_BIT = 4;
	localparam int PCM_BOV_BIT = 6;
	localparam int PCM_BROWNOUT_ENABLE_BIT = 7;
	// Clock config fields
	localparam int PCM_FILTER_BIT = 4;
	localparam int PCM_RCFS_BIT = 3;
	localparam int PCM_SRC_HI = 1;
	localparam int PCM_SRC_LO = 0;
	// Brownout config fields
	localparam int PCM_CFG_BROWNOUT_DISABLE_BIT = 7;
	localparam int PCM_CFG_BROWNOUT_LEVEL_BIT = 6;
	localparam int PCM_CFG_BROWNOUT_RESET_ENABLE_BIT = 4;
	localparam logic [7:0] PCM_CFG_RESET = 8'hff;
	localparam logic [7:0] PCM_DIV_RESET = 8'h00;
	localparam logic [31:0] PCM_WORD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		PCM_SRC_EXT = 2'b00,
		PCM_SRC_XTAL = 2'b01,
		PCM_SRC_RSVD = 2'b10,
		PCM_SRC_RC = 2'b11
	} pcm_src_t;
	typedef enum logic [1:0] {
		PCM_RUN = 2'b00,
		PCM_IDLE = 2'b01,
		PCM_PDOWN = 2'b10
	} pcm_pstate_t;
	typedef enum logic [1:0] {
		PCM_TA_LOCKED = 2'b00,
		PCM_TA_HALF = 2'b01,
		PCM_TA_OPEN = 2'b10
	} pcm_ta_t;
endpackage : pcm_pkg

// *** rtl/pcm_ctl_if.sv ***
`timescale 1ns/1ns
interface pcm_ctl_if;
	logic [7:0] divider;
	logic run;
	logic sys_tick;
	logic bod_enable;
	logic bod_rst_en;
	logic bod_flag_evt;
	logic bod_rst_evt;
	modport top (output divider, run, bod_enable, bod_rst_en, input sys_tick, bod_flag_evt,
		bod_rst_evt);
	modport div (input divider, run, output sys_tick);
	modport bod (input bod_enable, bod_rst_en, output bod_flag_evt, bod_rst_evt);
endinterface : pcm_ctl_if

// *** rtl/pcm_clk_div.sv ***
`timescale 1ns/1ns
module pcm_clk_div import pcm_pkg::*; (
	input wire logic clk_in, // Oscillator clock
	input wire logic rst_in, // Async reset, high
	pcm_ctl_if.div ctl // Divider value and tick
);
	typedef struct packed {
		logic [8:0] count;
		logic tick;
	} pcm_div_st_t;
	pcm_div_st_t st, next_st;
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!ctl.run) begin
			next_st.count = '0;
		end else if (ctl.divider == PCM_DIV_RESET) begin
			next_st.tick = 1'b1;
			next_st.count = '0;
		end else if (st.count >= {ctl.divider, 1'b1}) begin
			next_st.tick = 1'b1;
			next_st.count = '0;
		end else begin
			next_st.count = st.count + 9'h001;
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ctl.sys_tick = st.tick;
endmodule : pcm_clk_div

// *** rtl/pcm_bod_mon.sv ***
`timescale 1ns/1ns
module pcm_bod_mon import pcm_pkg::*; (
	input wire logic clk_in, // Oscillator clock
	input wire logic rst_in, // Async reset, high
	input wire logic supply_below_in, // Comparator, async
	pcm_ctl_if.bod ctl // Enables and events
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic flag_evt;
		logic rst_evt;
	} pcm_bod_st_t;
	pcm_bod_st_t st, next_st;
	logic crossed;
	always_comb begin
		next_st = st;
		next_st.s1 = supply_below_in;
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		// Both a drop below and a rise above count as an event
		crossed = ctl.bod_enable && (st.s2 != st.prev);
		next_st.rst_evt = crossed && ctl.bod_rst_en;
		next_st.flag_evt = crossed && !ctl.bod_rst_en;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign ctl.bod_flag_evt = st.flag_evt;
	assign ctl.bod_rst_evt = st.rst_evt;
endmodule : pcm_bod_mon

// *** rtl/pcm_top.sv ***
// Summary of operation
// - Idle request write halts core after write
// - Idle freezes core, peripherals keep clocks
// - Enabled interrupt ends idle, clears bit
// - Non-software resets also end idle
// - Power-down request stops whole clock system
// - Non-software resets end power-down
// - Enabled external pin interrupt wakes power-down
// - Brownout, watchdog, keypad interrupts also wake
// - Keypad wakes only on opposite edge
// - Two config bits select clock source
// - RC frequency bit bypasses divide-by-two
// - Config bit four enables crystal filter
// - Divider zero passes, else divide 2(n+1)
// - Power-up sets flag; software clears it
// - Brownout level from inverted config bit
// - Brownout enable reloaded inverted each reset
// - Threshold crossing resets core or flags
// - Cleared flag stays clear until recrossing
// - Both requests set means power-down only
// - Watchdog cleared on entry and wake
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
module pcm_top import pcm_pkg::*; #(
	parameter int EXT_IRQS = 2, // External interrupt pins
	parameter int KBD_PINS = 8 // Keypad pins
) (
	input wire logic clk_in, // Oscillator clock
	input wire logic rst_in, // Power-on reset, async high
	input wire logic hsel_in, // AHB select
	input wire logic [31:0] haddr_in, // AHB address
	input wire logic [1:0] htrans_in, // AHB transfer type
	input wire logic hwrite_in, // AHB write
	input wire logic [2:0] hsize_in, // AHB size
	input wire logic [31:0] hwdata_in, // AHB write data
	input wire logic hready_in, // AHB ready in
	output logic [31:0] hrdata_out, // AHB read data
	output logic hreadyout_out, // AHB ready out
	output logic hresp_out, // AHB response
	input wire logic pin_reset_in, // Reset pin, async high
	input wire logic wdt_reset_in, // Watchdog reset pulse
	input wire logic sw_reset_in, // Software reset pulse
	input wire logic irq_pending_in, // Any enabled interrupt pending
	input wire logic global_irq_enable_in, // Global interrupt enable
	input wire logic [EXT_IRQS-1:0] ext_irq_pin_in, // External irq pins, async
	input wire logic [EXT_IRQS-1:0] ext_irq_enable_in, // Per-pin enables
	input wire logic wdt_irq_in, // Watchdog interrupt
	input wire logic [KBD_PINS-1:0] kbd_pin_in, // Keypad pins, async
	input wire logic kbd_irq_enable_in, // Keypad interrupt enable
	input wire logic supply_below_in, // Supply below threshold, async
	output logic core_halt_out, // Core stops fetching
	output logic clk_stop_out, // Whole clock system stopped
	output logic sys_clk_tick_out, // System clock enable
	output logic [1:0] clk_src_out, // Selected oscillator
	output logic rc_div2_out, // RC through halving path
	output logic xtal_filter_out, // Crystal input filter on
	output logic brownout_level_out, // High selects higher level
	output logic brownout_enable_out, // Brownout detector on
	output logic brownout_flag_out, // Brownout interrupt request
	output logic core_reset_out, // Core reset pulse
	output logic wdt_clear_out // Watchdog clear pulse
);
	typedef struct packed {
		pcm_pstate_t pstate;
		pcm_ta_t ta;
		logic [3:0] ta_count;
		logic idle_bit;
		logic pd_bit;
		logic power_on_flag;
		logic [7:0] divider;
		logic [7:0] clk_cfg;
		logic [7:0] bod_cfg;
		logic bod_en;
		logic bod_level;
		logic bod_rst_en;
		logic bod_flag;
		logic dp_write;
		logic [7:0] dp_index;
		logic [31:0] rdata;
		logic [EXT_IRQS-1:0] ext_s1;
		logic [EXT_IRQS-1:0] ext_s2;
		logic [KBD_PINS-1:0] kbd_s1;
		logic [KBD_PINS-1:0] kbd_s2;
		logic [KBD_PINS-1:0] kbd_entry;
		logic prst_s1;
		logic prst_s2;
		logic core_halt;
		logic clk_stop;
		logic core_reset;
		logic wdt_clear;
		logic [1:0] clk_src;
		logic rc_div2;
		logic xtal_filter;
	} pcm_top_st_t;

	pcm_top_st_t st, next_st;
	pcm_ctl_if ctl ();

	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		reg_index = addr[PCM_ADDR_W-1:2];
	endfunction : reg_index

	function automatic logic [1:0] src_decode(input logic [7:0] cfg);
		logic [1:0] sel;
		sel = {cfg[PCM_SRC_HI], cfg[PCM_SRC_LO]};
		// Reserved code falls back to the RC oscillator
		src_decode = (sel == PCM_SRC_RSVD) ? PCM_SRC_RC : sel;
	endfunction : src_decode

	logic addr_phase;
	logic [7:0] a_index;
	logic [7:0] wbyte;
	logic reset_req;
	logic wake_pd;
	logic enter_idle;
	logic enter_pd;
	logic waking;
	logic [31:0] rword;

	always_comb begin
		next_st = st;
		next_st.wdt_clear = 1'b0;
		next_st.core_reset = 1'b0;
		addr_phase = hsel_in && htrans_in[1] && hready_in;
		a_index = reg_index(haddr_in);
		wbyte = hwdata_in[7:0];
		enter_idle = 1'b0;
		enter_pd = 1'b0;
		waking = 1'b0;
		next_st.ext_s1 = ext_irq_pin_in;
		next_st.ext_s2 = st.ext_s1;
		next_st.kbd_s1 = kbd_pin_in;
		next_st.kbd_s2 = st.kbd_s1;
		next_st.prst_s1 = pin_reset_in;
		next_st.prst_s2 = st.prst_s1;

		// Read data is prepared in the address phase
		rword = PCM_WORD_ZERO;
		case (a_index)
			PCM_IDX_POWER_CONTROL: begin
				rword[PCM_POF_BIT] = st.power_on_flag;
				rword[PCM_PD_BIT] = st.pd_bit;
				rword[PCM_IDLE_BIT] = st.idle_bit;
			end
			PCM_IDX_DIVIDER: begin
				rword[7:0] = st.divider;
			end
			PCM_IDX_POWER_MONITOR: begin
				rword[PCM_BROWNOUT_ENABLE_BIT] = st.bod_en;
				rword[PCM_BOV_BIT] = st.bod_level;
				rword[PCM_BROWNOUT_RESET_ENABLE_BIT] = st.bod_rst_en;
				rword[PCM_BOF_BIT] = st.bod_flag;
			end
			PCM_IDX_CLOCK_CFG: begin
				rword[7:0] = st.clk_cfg;
			end
			PCM_IDX_BROWNOUT_CFG: begin
				rword[7:0] = st.bod_cfg;
			end
			default: begin
				rword = PCM_WORD_ZERO;
			end
		endcase
		if (addr_phase && !hwrite_in) begin
			next_st.rdata = rword;
		end
		next_st.dp_write = addr_phase && hwrite_in;
		if (addr_phase) begin
			next_st.dp_index = a_index;
		end

		// Window closes on its own after a fixed number of cycles
		if (st.ta == PCM_TA_OPEN) begin
			if (st.ta_count == '0) begin
				next_st.ta = PCM_TA_LOCKED;
			end else begin
				next_st.ta_count = st.ta_count - 4'h1;
			end
		end

		// Write data phase
		if (st.dp_write) begin
			case (st.dp_index)
				PCM_IDX_POWER_CONTROL: begin
					next_st.power_on_flag = wbyte[PCM_POF_BIT];
					next_st.pd_bit = wbyte[PCM_PD_BIT];
					next_st.idle_bit = wbyte[PCM_IDLE_BIT];
					enter_pd = wbyte[PCM_PD_BIT];
					enter_idle = wbyte[PCM_IDLE_BIT] && !wbyte[PCM_PD_BIT];
				end
				PCM_IDX_DIVIDER: begin
					next_st.divider = wbyte;
				end
				PCM_IDX_TA_KEY: begin
					if (wbyte == PCM_TA_KEY1) begin
						next_st.ta = PCM_TA_HALF;
					end else if (wbyte == PCM_TA_KEY2 && st.ta == PCM_TA_HALF) begin
						next_st.ta = PCM_TA_OPEN;
						next_st.ta_count = PCM_TA_WINDOW;
					end else begin
						next_st.ta = PCM_TA_LOCKED;
					end
				end
				PCM_IDX_POWER_MONITOR: begin
					if (st.ta == PCM_TA_OPEN) begin
						next_st.bod_en = wbyte[PCM_BROWNOUT_ENABLE_BIT];
						next_st.bod_level = wbyte[PCM_BOV_BIT];
						next_st.bod_rst_en = wbyte[PCM_BROWNOUT_RESET_ENABLE_BIT];
						next_st.bod_flag = wbyte[PCM_BOF_BIT];
						next_st.ta = PCM_TA_LOCKED;
					end
				end
				PCM_IDX_CLOCK_CFG: begin
					next_st.clk_cfg = wbyte;
				end
				PCM_IDX_BROWNOUT_CFG: begin
					next_st.bod_cfg = wbyte;
				end
				default: begin
					next_st.ta = st.ta;
				end
			endcase
		end

		// Hardware set wins over a software clear
		if (ctl.bod_flag_evt) begin
			next_st.bod_flag = 1'b1;
		end

		// Power state sequencing
		wake_pd = (|(st.ext_s2 & ext_irq_enable_in) && global_irq_enable_in)
			|| wdt_irq_in || ctl.bod_flag_evt
			|| (kbd_irq_enable_in && (st.kbd_s2 != st.kbd_entry));
		case (st.pstate)
			PCM_RUN: begin
				if (enter_pd) begin
					next_st.pstate = PCM_PDOWN;
					next_st.kbd_entry = st.kbd_s2;
					next_st.wdt_clear = 1'b1;
				end else if (enter_idle) begin
					next_st.pstate = PCM_IDLE;
					next_st.wdt_clear = 1'b1;
				end
			end
			PCM_IDLE: begin
				if (irq_pending_in) begin
					waking = 1'b1;
				end
			end
			PCM_PDOWN: begin
				if (wake_pd) begin
					waking = 1'b1;
				end
			end
			default: begin
				next_st.pstate = PCM_RUN;
			end
		endcase
		if (waking) begin
			next_st.pstate = PCM_RUN;
			next_st.idle_bit = 1'b0;
			next_st.pd_bit = 1'b0;
			next_st.wdt_clear = 1'b1;
		end

		// Software reset is ignored while the core sleeps
		reset_req = st.prst_s2 || wdt_reset_in || ctl.bod_rst_evt
			|| (sw_reset_in && st.pstate == PCM_RUN);
		if (reset_req) begin
			next_st.core_reset = 1'b1;
			next_st.wdt_clear = st.pstate != PCM_RUN;
			next_st.pstate = PCM_RUN;
			next_st.idle_bit = 1'b0;
			next_st.pd_bit = 1'b0;
			next_st.divider = PCM_DIV_RESET;
			next_st.ta = PCM_TA_LOCKED;
			next_st.bod_en = !st.bod_cfg[PCM_CFG_BROWNOUT_DISABLE_BIT];
			next_st.bod_level = !st.bod_cfg[PCM_CFG_BROWNOUT_LEVEL_BIT];
			next_st.bod_rst_en = st.bod_cfg[PCM_CFG_BROWNOUT_RESET_ENABLE_BIT];
			next_st.bod_flag = st.bod_flag || ctl.bod_flag_evt;
		end

		next_st.core_halt = next_st.pstate != PCM_RUN;
		next_st.clk_stop = next_st.pstate == PCM_PDOWN;
		next_st.clk_src = src_decode(st.clk_cfg);
		next_st.rc_div2 = (src_decode(st.clk_cfg) == PCM_SRC_RC)
			&& !st.clk_cfg[PCM_RCFS_BIT];
		next_st.xtal_filter = st.clk_cfg[PCM_FILTER_BIT];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st <= '0;
			st.pstate <= PCM_RUN;
			st.ta <= PCM_TA_LOCKED;
			st.power_on_flag <= 1'b1;
			st.divider <= PCM_DIV_RESET;
			st.clk_cfg <= PCM_CFG_RESET;
			st.bod_cfg <= PCM_CFG_RESET;
			st.bod_en <= !PCM_CFG_RESET[PCM_CFG_BROWNOUT_DISABLE_BIT];
			st.bod_level <= !PCM_CFG_RESET[PCM_CFG_BROWNOUT_LEVEL_BIT];
			st.bod_rst_en <= PCM_CFG_RESET[PCM_CFG_BROWNOUT_RESET_ENABLE_BIT];
			st.clk_src <= PCM_SRC_RC;
			st.xtal_filter <= PCM_CFG_RESET[PCM_FILTER_BIT];
		end else begin
			st <= next_st;
		end
	end

	// Peripheral clock divider halts in power-down
	assign ctl.divider = st.divider;
	assign ctl.run = !st.clk_stop;
	assign ctl.bod_enable = st.bod_en;
	assign ctl.bod_rst_en = st.bod_rst_en;

	pcm_clk_div u_div (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ctl(ctl)
	);

	pcm_bod_mon u_bod (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.supply_below_in(supply_below_in),
		.ctl(ctl)
	);

	assign hrdata_out = st.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign core_halt_out = st.core_halt;
	assign clk_stop_out = st.clk_stop;
	assign sys_clk_tick_out = ctl.sys_tick;
	assign clk_src_out = st.clk_src;
	assign rc_div2_out = st.rc_div2;
	assign xtal_filter_out = st.xtal_filter;
	assign brownout_level_out = st.bod_level;
	assign brownout_enable_out = st.bod_en;
	assign brownout_flag_out = st.bod_flag;
	assign core_reset_out = st.core_reset;
	assign wdt_clear_out = st.wdt_clear;
endmodule : pcm_top

// *** testbench/pcm_top_assertions.sv ***
`timescale 1ns/1ns
module pcm_top_assertions import pcm_pkg::*; #(
	parameter int EXT_IRQS = 2, // External interrupt pins
	parameter int KBD_PINS = 8 // Keypad pins
) (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset, high
	input wire logic hsel_in, // AHB select
	input wire logic [31:0] haddr_in, // AHB address
	input wire logic [1:0] htrans_in, // AHB transfer
	input wire logic hwrite_in, // AHB write
	input wire logic [31:0] hwdata_in, // AHB write data
	input wire logic hready_in, // AHB ready
	input wire logic irq_pending_in, // Interrupt pending
	input wire logic global_irq_enable_in, // Global enable
	input wire logic [EXT_IRQS-1:0] ext_irq_pin_in, // External pins
	input wire logic [EXT_IRQS-1:0] ext_irq_enable_in, // Pin enables
	input wire logic wdt_irq_in, // Watchdog interrupt
	input wire logic core_halt_out, // Core halted
	input wire logic clk_stop_out, // Clocks stopped
	input wire logic sys_clk_tick_out, // System tick
	input wire logic [1:0] clk_src_out, // Clock source
	input wire logic rc_div2_out, // RC halved
	input wire logic wdt_clear_out // Watchdog clear
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Address phase of a write to the power control register
	sequence s_pc_addr;
		hsel_in && htrans_in[1] && hready_in && hwrite_in
			&& haddr_in[9:2] == PCM_IDX_POWER_CONTROL;
	endsequence
	sequence s_idle_req;
		s_pc_addr ##1 (hwdata_in[PCM_IDLE_BIT] && !hwdata_in[PCM_PD_BIT]);
	endsequence
	sequence s_pd_req;
		s_pc_addr ##1 hwdata_in[PCM_PD_BIT];
	endsequence
	a_idle_entry: assert property (s_idle_req |-> ##[1:2] core_halt_out)
		else $error("idle request did not halt core");
	a_pd_entry: assert property (s_pd_req |-> ##[1:2] clk_stop_out)
		else $error("power-down request did not stop clocks");
	a_idle_wake: assert property (core_halt_out && !clk_stop_out && irq_pending_in
		|-> ##[1:3] !core_halt_out) else $error("interrupt did not end idle");
	a_ext_wake: assert property (clk_stop_out && global_irq_enable_in
		&& |(ext_irq_pin_in & ext_irq_enable_in) |-> ##[1:6] !clk_stop_out)
		else $error("external pin did not wake");
	a_wdt_wake: assert property (clk_stop_out && wdt_irq_in |-> ##[1:3] !clk_stop_out)
		else $error("watchdog interrupt did not wake");
	a_tick_frozen: assert property (clk_stop_out && $past(clk_stop_out)
		|-> !sys_clk_tick_out) else $error("tick while clocks stopped");
	a_stop_halts: assert property (clk_stop_out |-> core_halt_out)
		else $error("clocks stopped with core running");
	a_src_legal: assert property (clk_src_out != PCM_SRC_RSVD)
		else $error("reserved clock source reported");
	a_div2_rc: assert property (rc_div2_out |-> clk_src_out == PCM_SRC_RC)
		else $error("halving path outside RC mode");
	a_wdt_entry: assert property ($rose(core_halt_out)
		|-> wdt_clear_out || $past(wdt_clear_out)) else $error("no watchdog clear on entry");
	a_wdt_pulse: assert property (wdt_clear_out |=> !wdt_clear_out)
		else $error("watchdog clear longer than one cycle");
endmodule : pcm_top_assertions

// *** testbench/pcm_core_model.sv ***
`timescale 1ns/1ns
module pcm_core_model #(
	parameter int DELAY = 30 // Cycles from idle to interrupt
) (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Reset, high
	input wire logic halt_in, // Core halted
	input wire logic stop_in, // Clocks stopped
	input wire logic arm_in, // Raise an interrupt in idle
	output logic irq_out // Enabled interrupt pending
);
	int cnt;
	// Peripheral interrupt only fires while clocks still run in idle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 0;
			irq_out <= 1'b0;
		end else if (halt_in && !stop_in && arm_in) begin
			cnt <= cnt + 1;
			irq_out <= (cnt >= DELAY);
		end else begin
			cnt <= 0;
			irq_out <= 1'b0;
		end
	end
endmodule : pcm_core_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
bind pcm_top pcm_top_assertions #(.EXT_IRQS(EXT_IRQS), .KBD_PINS(KBD_PINS)) u_chk (
	.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
	.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
	.irq_pending_in(irq_pending_in), .global_irq_enable_in(global_irq_enable_in),
	.ext_irq_pin_in(ext_irq_pin_in), .ext_irq_enable_in(ext_irq_enable_in),
	.wdt_irq_in(wdt_irq_in), .core_halt_out(core_halt_out), .clk_stop_out(clk_stop_out),
	.sys_clk_tick_out(sys_clk_tick_out), .clk_src_out(clk_src_out),
	.rc_div2_out(rc_div2_out), .wdt_clear_out(wdt_clear_out));
module tb import pcm_pkg::*; ;
	logic clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0, arm = 1'b0;
	logic pin_reset_in = 1'b0, wdt_reset_in = 1'b0, sw_reset_in = 1'b0, wdt_irq_in = 1'b0;
	logic global_irq_enable_in = 1'b0, kbd_irq_enable_in = 1'b0, supply_below_in = 1'b0;
	logic [31:0] haddr_in = PCM_WORD_ZERO, hwdata_in = PCM_WORD_ZERO, hrdata_out;
	logic [1:0] htrans_in = 2'h0, ext_irq_pin_in = 2'h0, ext_irq_enable_in = 2'h0, clk_src_out;
	logic [2:0] hsize_in = 3'h2;
	logic [7:0] kbd_pin_in = 8'h00;
	logic irq_pending_in, hreadyout_out, hresp_out, core_halt_out, clk_stop_out, rc_div2_out;
	logic sys_clk_tick_out, xtal_filter_out, brownout_level_out, brownout_enable_out;
	logic brownout_flag_out, core_reset_out, wdt_clear_out;
	wire logic [4:0] st = {core_reset_out, brownout_flag_out, sys_clk_tick_out, clk_stop_out,
		core_halt_out};
	int n_fail = 0, comparisons = 0, n_wc = 0, n_tk = 0;
	pcm_top dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
		.htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
		.hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out), .pin_reset_in(pin_reset_in), .wdt_reset_in(wdt_reset_in),
		.sw_reset_in(sw_reset_in), .irq_pending_in(irq_pending_in),
		.global_irq_enable_in(global_irq_enable_in), .ext_irq_pin_in(ext_irq_pin_in),
		.ext_irq_enable_in(ext_irq_enable_in), .wdt_irq_in(wdt_irq_in), .kbd_pin_in(kbd_pin_in),
		.kbd_irq_enable_in(kbd_irq_enable_in), .supply_below_in(supply_below_in),
		.core_halt_out(core_halt_out), .clk_stop_out(clk_stop_out),
		.sys_clk_tick_out(sys_clk_tick_out), .clk_src_out(clk_src_out), .rc_div2_out(rc_div2_out),
		.xtal_filter_out(xtal_filter_out), .brownout_level_out(brownout_level_out),
		.brownout_enable_out(brownout_enable_out), .brownout_flag_out(brownout_flag_out),
		.core_reset_out(core_reset_out), .wdt_clear_out(wdt_clear_out));
	pcm_core_model #(.DELAY(30)) u_core (.clk_in(clk_in), .rst_in(rst_in),
		.halt_in(core_halt_out), .stop_in(clk_stop_out), .arm_in(arm), .irq_out(irq_pending_in));
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		n_wc <= n_wc + int'(wdt_clear_out === 1'b1);
		n_tk <= n_tk + int'(sys_clk_tick_out === 1'b1);
	end
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Bounded wait for status bit b to reach v
	task automatic wv(input int b, input logic v);
		int k;
		for (k = 0; k < 100 && st[b] !== v; k++) @(posedge clk_in);
		if (k == 100) begin
			n_fail++;
			summarize;
		end
	endtask : wv
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (hreadyout_out !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_fail++;
			summarize;
		end
	endtask : rdy
	task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		hsel_in <= 1'b1;
		haddr_in <= {22'h00_0000, i, 2'b00};
		htrans_in <= 2'b10;
		hwrite_in <= w;
		rdy;
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= {24'h00_0000, d};
		rdy;
		q = hrdata_out;
	endtask : bus
	task automatic wr(input logic [7:0] i, d);
		logic [31:0] q;
		bus(i, 1'b1, d, q);
	endtask : wr
	task automatic rc(input string nm, input logic [7:0] i, e);
		logic [31:0] q;
		bus(i, 1'b0, 8'h00, q);
		chk(nm, q, {24'h00_0000, e});
	endtask : rc
	task automatic ul;
		wr(PCM_IDX_TA_KEY, PCM_TA_KEY1);
		wr(PCM_IDX_TA_KEY, PCM_TA_KEY2);
	endtask : ul
	task automatic t_reset;
		rc("pof", PCM_IDX_POWER_CONTROL, 8'h10);
		rc("div", PCM_IDX_DIVIDER, PCM_DIV_RESET);
		rc("power_monitor_control", PCM_IDX_POWER_MONITOR, 8'h10);
		rc("ccfg", PCM_IDX_CLOCK_CFG, PCM_CFG_RESET);
		rc("bcfg", PCM_IDX_BROWNOUT_CFG, PCM_CFG_RESET);
		rc("key", PCM_IDX_TA_KEY, 8'h00);
		rc("unmapped", 8'h40, 8'h00);
		chk("bod outs", 32'({brownout_level_out, brownout_enable_out}), PCM_WORD_ZERO);
		wr(PCM_IDX_POWER_CONTROL, 8'h00);
		rc("pof clear", PCM_IDX_POWER_CONTROL, 8'h00);
	endtask : t_reset
	task automatic t_clk;
		logic [7:0] cf [4] = '{8'h03, 8'h19, 8'h0a, 8'h10};
		logic [3:0] ex [4] = '{4'b1110, 4'b0101, 4'b1100, 4'b0001};
		for (int i = 0; i < 4; i++) begin
			wr(PCM_IDX_CLOCK_CFG, cf[i]);
			repeat (3) @(posedge clk_in);
			chk("clk", 32'({clk_src_out, rc_div2_out, xtal_filter_out}), 32'(ex[i]));
		end
		wr(PCM_IDX_CLOCK_CFG, PCM_CFG_RESET);
	endtask : t_clk
	task automatic t_div;
		logic [7:0] dv [3] = '{8'h00, 8'h01, 8'h04};
		int k;
		for (int i = 0; i < 3; i++) begin
			wr(PCM_IDX_DIVIDER, dv[i]);
			repeat (20) @(posedge clk_in);
			wv(2, 1'b1);
			k = 0;
			do begin
				@(posedge clk_in);
				k++;
			end while (sys_clk_tick_out !== 1'b1 && k < 600);
			chk("tick period", 32'(k), 32'((dv[i] == 8'h00) ? 1 : 2 * (dv[i] + 1)));
		end
	endtask : t_div
	task automatic t_idle;
		int w, t;
		w = n_wc;
		arm <= 1'b1;
		wr(PCM_IDX_POWER_CONTROL, 8'h01);
		wv(0, 1'b1);
		t = n_tk;
		chk("idle stop", 32'(clk_stop_out), PCM_WORD_ZERO);
		wv(0, 1'b0);
		repeat (2) @(posedge clk_in);
		chk("idle ticks", 32'(n_tk > t), 32'(1'b1));
		chk("wdt clears", 32'(n_wc - w), 32'(2));
		arm <= 1'b0;
		rc("idle bit", PCM_IDX_POWER_CONTROL, 8'h00);
	endtask : t_idle
	task automatic t_pd;
		int t;
		ext_irq_enable_in <= 2'b01;
		kbd_irq_enable_in <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(PCM_IDX_POWER_CONTROL, (s == 0) ? 8'h03 : 8'h02);
			wv(1, 1'b1);
			@(posedge clk_in);
			t = n_tk;
			repeat (20) @(posedge clk_in);
			chk("pd ticks", 32'(n_tk - t), PCM_WORD_ZERO);
			case (s)
				0: ext_irq_pin_in <= 2'b01;
				1: wdt_irq_in <= 1'b1;
				2: kbd_pin_in <= 8'h04;
				default: kbd_pin_in <= 8'h00;
			endcase
			repeat (20) @(posedge clk_in);
			chk("wake", 32'(clk_stop_out), 32'(s == 0));
			global_irq_enable_in <= 1'b1;
			wv(1, 1'b0);
			repeat (4) @(posedge clk_in);
			chk("pd halt", 32'(core_halt_out), PCM_WORD_ZERO);
			ext_irq_pin_in <= 2'b00;
			wdt_irq_in <= 1'b0;
			rc("pd bits", PCM_IDX_POWER_CONTROL, 8'h00);
		end
	endtask : t_pd
	task automatic t_bod;
		wr(PCM_IDX_POWER_MONITOR, 8'hc0);
		chk("refused resp", 32'(hresp_out), PCM_WORD_ZERO);
		rc("locked", PCM_IDX_POWER_MONITOR, 8'h10);
		ul;
		wr(PCM_IDX_POWER_MONITOR, 8'hc0);
		rc("unlocked", PCM_IDX_POWER_MONITOR, 8'hc0);
		wr(PCM_IDX_POWER_MONITOR, 8'h10);
		rc("relocked", PCM_IDX_POWER_MONITOR, 8'hc0);
		chk("bod outs", 32'({brownout_level_out, brownout_enable_out}), 32'(2'b11));
		supply_below_in <= 1'b1;
		wv(3, 1'b1);
		rc("drop flag", PCM_IDX_POWER_MONITOR, 8'hc8);
		ul;
		wr(PCM_IDX_POWER_MONITOR, 8'hc0);
		repeat (20) @(posedge clk_in);
		rc("stay clear", PCM_IDX_POWER_MONITOR, 8'hc0);
		supply_below_in <= 1'b0;
		wv(3, 1'b1);
		rc("rise flag", PCM_IDX_POWER_MONITOR, 8'hc8);
		ul;
		wr(PCM_IDX_POWER_MONITOR, 8'hd0);
		supply_below_in <= 1'b1;
		wv(4, 1'b1);
		repeat (4) @(posedge clk_in);
		rc("reload", PCM_IDX_POWER_MONITOR, 8'h10);
		rc("div reload", PCM_IDX_DIVIDER, 8'h00);
	endtask : t_bod
	task automatic t_rst;
		wr(PCM_IDX_DIVIDER, 8'h07);
		wr(PCM_IDX_POWER_CONTROL, 8'h01);
		wv(0, 1'b1);
		sw_reset_in <= 1'b1;
		@(posedge clk_in);
		sw_reset_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		chk("sw in idle", 32'(core_halt_out), 32'(1'b1));
		pin_reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		pin_reset_in <= 1'b0;
		wv(0, 1'b0);
		rc("div", PCM_IDX_DIVIDER, 8'h00);
		rc("pof kept", PCM_IDX_POWER_CONTROL, 8'h00);
		wr(PCM_IDX_POWER_CONTROL, 8'h02);
		wv(1, 1'b1);
		wdt_reset_in <= 1'b1;
		@(posedge clk_in);
		wdt_reset_in <= 1'b0;
		wv(1, 1'b0);
		rc("pd cleared", PCM_IDX_POWER_CONTROL, 8'h00);
	endtask : t_rst
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset;
		t_clk;
		t_div;
		t_idle;
		t_pd;
		t_bod;
		t_rst;
		summarize;
	end
endmodule : tb
